// *** ptif_pkg.sv ***
// Package for the PWM and touch-key interrupt flag block.
// Holds register offsets, field positions, reset values and masks.
// Assumes an Avalon-MM slave with 32-bit data and byte addresses.
package ptif_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] PTIF_IDX_ENABLE = 8'h84;
  localparam logic [7:0] PTIF_IDX_FLAGS  = 8'h85;
  localparam logic [7:0] PTIF_IDX_IRQST  = 8'h86;

  // Byte addresses of the registers.
  localparam logic [9:0] PTIF_ADR_ENABLE = {PTIF_IDX_ENABLE, 2'b00};
  localparam logic [9:0] PTIF_ADR_FLAGS  = {PTIF_IDX_FLAGS, 2'b00};
  localparam logic [9:0] PTIF_ADR_IRQST  = {PTIF_IDX_IRQST, 2'b00};

  // Field positions, shared by enable and flag registers.
  localparam int PTIF_BIT_PWM_GROUP = 6;
  localparam int PTIF_BIT_PWM_CH0   = 5;
  localparam int PTIF_BIT_TOUCH_B   = 1;
  localparam int PTIF_BIT_TOUCH_A   = 0;

  // Implemented bits; the rest read as zero.
  localparam logic [7:0] PTIF_IMPL_MASK = 8'h63;

  // Reset values.
  localparam logic [7:0] PTIF_RST_ENABLE = 8'h00;
  localparam logic [7:0] PTIF_RST_FLAGS  = 8'h00;

  // Clearing byte values that software writes for each flag.
  localparam logic [7:0] PTIF_CLR_PWM_GROUP = 8'hbf;
  localparam logic [7:0] PTIF_CLR_PWM_CH0   = 8'hdf;
  localparam logic [7:0] PTIF_CLR_TOUCH_B   = 8'hfd;
  localparam logic [7:0] PTIF_CLR_TOUCH_A   = 8'hfe;

  // Answer to a read of an unmapped address.
  localparam logic [31:0] PTIF_RD_UNMAPPED = 32'h0000_0000;

endpackage

// *** ptif_event_if.sv ***
// Interface carrying the four hardware events between the edge stage and the top.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface ptif_event_if;
  logic [7:0] set_pulse; // One-cycle set request per flag position.
  modport src (output set_pulse);
  modport dst (input set_pulse);
endinterface
`default_nettype wire

// *** ptif_event_edge.sv ***
// Turns level event inputs into one-cycle set pulses at the rising edge.
// Assumes the event inputs are from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ptif_event_edge
  import ptif_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Raw event levels placed at flag positions.
  input  wire logic [7:0] event_lvl,
  // Set pulses toward the flag register.
  ptif_event_if.src       ev
);

  logic [7:0] prev_r;   // Event levels of the previous cycle.
  logic [7:0] prev_nxt; // Next value of the level store.

  // Remember the levels so a held event sets its flag only once.
  always_comb begin
    prev_nxt = event_lvl & PTIF_IMPL_MASK;
  end

  // Register the levels.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 8'h00;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // A pulse marks the cycle in which an event level rises.
  assign ev.set_pulse = event_lvl & ~prev_r & PTIF_IMPL_MASK;

endmodule
`default_nettype wire

// *** ptif_top.sv ***
// Contract
// [R1] PWM channel 1 period end sets bit 6.
// [R2] Writing bfh clears only the group flag.
// [R3] Channel 0 period sets bit 5; dfh clears.
// [R4] Engine B scan sets bit 1; fdh clears.
// [R5] Engine A scan sets bit 0; feh clears.
// [R6] Enable bit 6 gates grouped PWM interrupt.
// [R7] Enable bit 5 gates channel 0 interrupt.
// [R8] Enable bit 1 gates engine B interrupt.
// [R9] Enable bit 0 gates engine A interrupt.
// [R10] All enables and flags reset to zero.
// [R11] Zero clears, one keeps; set beats clear.
// [R12] Request held while flag and enable set.
//
// Top of the PWM and touch-key interrupt flag block.
// Assumes an Avalon-MM master on clk and event strobes on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ptif_top
  import ptif_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave.
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Event levels from the PWM and touch-key engines.
  input  wire logic        pwm_group_period_end,
  input  wire logic        pwm_ch0_period_end,
  input  wire logic        touch_b_scan_done,
  input  wire logic        touch_a_scan_done,
  // Interrupt requests.
  output logic      [7:0]  irq_req,
  output logic             irq
);

  ptif_event_if ev_if ();                 // Set pulses from the edge stage.

  logic [7:0]  event_lvl;                 // Events placed at flag positions.
  logic [7:0]  enable_r;                  // Enable register.
  logic [7:0]  enable_nxt;                // Next enable value.
  logic [7:0]  flags_r;                   // Flag register.
  logic [7:0]  flags_nxt;                 // Next flag value.
  logic [7:0]  req_r;                     // Registered per-source requests.
  logic [7:0]  req_nxt;                   // Next per-source requests.
  logic        irq_r;                     // Registered combined request.
  logic        irq_nxt;                   // Next combined request.
  logic        ack_r;                     // High in the answer cycle.
  logic        ack_nxt;                   // Next answer flag.
  logic        wait_r;                    // Registered waitrequest, high while idle.
  logic        wait_nxt;                  // Next waitrequest.
  logic [31:0] rdata_r;                   // Registered read data.
  logic [31:0] rdata_nxt;                 // Next read data.
  logic        wr_take;                   // Write accepted this cycle.
  logic        rd_take;                   // Read seen; its data are captured now.

  // Map the engine events onto their flag positions.
  always_comb begin
    event_lvl = 8'h00;
    event_lvl[PTIF_BIT_PWM_GROUP] = pwm_group_period_end; // R1
    event_lvl[PTIF_BIT_PWM_CH0]   = pwm_ch0_period_end;   // R3
    event_lvl[PTIF_BIT_TOUCH_B]   = touch_b_scan_done;    // R4
    event_lvl[PTIF_BIT_TOUCH_A]   = touch_a_scan_done;    // R5
  end

  // Edge stage so a long event level sets its flag once only.
  ptif_event_edge u_edge (
    .clk       (clk),
    .reset_n   (reset_n),
    .event_lvl (event_lvl),
    .ev        (ev_if.src)
  );

  // Every access takes one wait cycle, then completes in the answer cycle.
  // A write acts at the end of the answer cycle, when the master sees waitrequest low.
  assign wr_take = avs_write & ack_r;
  // A read is captured in its first cycle, so the data already stand in a register
  // when the answer comes; the price is that the value is one cycle old.
  assign rd_take = avs_read & ~ack_r;

  // Handshake state. Waitrequest has its own register so that the pin comes
  // straight from a flip-flop; it is always the inverse of the answer flag.
  always_comb begin
    ack_nxt  = (avs_read | avs_write) & ~ack_r;
    wait_nxt = ~ack_nxt;
  end

  // Register and flag update logic.
  always_comb begin
    enable_nxt = enable_r;
    flags_nxt  = flags_r;
    // Only byte lane 0 holds register data; other lanes are ignored.
    if (wr_take && avs_byteenable[0]) begin
      if (avs_address == PTIF_ADR_ENABLE) begin
        enable_nxt = avs_writedata[7:0] & PTIF_IMPL_MASK;
      end else if (avs_address == PTIF_ADR_FLAGS) begin
        // A zero clears its flag and a one leaves it, so bfh touches bit 6 only.
        flags_nxt = flags_r & avs_writedata[7:0]; // R11 R2 R3 R4 R5
      end else if (avs_address == PTIF_ADR_IRQST) begin
        // Read-only status; writes are ignored.
        flags_nxt = flags_r;
      end
    end
    // Hardware set wins over a same-cycle software clear.
    flags_nxt = (flags_nxt | ev_if.set_pulse) & PTIF_IMPL_MASK; // R11 R1
  end

  // Requests follow flag and enable in the same cycle, through one register stage.
  always_comb begin
    req_nxt = flags_nxt & enable_nxt;  // R12 R6 R7 R8 R9
    irq_nxt = |req_nxt;                // R12
  end

  // Read data mux. The data are taken when a read is first seen and then stand
  // unchanged through the answer cycle, because only a new read loads them.
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_take) begin
      if (avs_address == PTIF_ADR_ENABLE) begin
        rdata_nxt = {24'h000000, enable_r};
      end else if (avs_address == PTIF_ADR_FLAGS) begin
        rdata_nxt = {24'h000000, flags_r};
      end else if (avs_address == PTIF_ADR_IRQST) begin
        rdata_nxt = {24'h000000, req_r};
      end else begin
        rdata_nxt = PTIF_RD_UNMAPPED;
      end
    end
  end

  // Register everything; reset clears all enables and flags.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= PTIF_RST_ENABLE; // R10
      flags_r  <= PTIF_RST_FLAGS;  // R10
      req_r    <= 8'h00;
      irq_r    <= 1'b0;
      ack_r    <= 1'b0;
      wait_r   <= 1'b1;
      rdata_r  <= 32'h0000_0000;
    end else begin
      enable_r <= enable_nxt;
      flags_r  <= flags_nxt;
      req_r    <= req_nxt;
      irq_r    <= irq_nxt;
      ack_r    <= ack_nxt;
      wait_r   <= wait_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Every output is a register, so no pin glitches while the address decodes.
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq_req         = req_r;
  assign irq             = irq_r;

  // Checks on the flag, enable and request behaviour. All run on the system
  // clock; all but the reset check are off while reset is held.

  // Right after reset every enable and flag must read zero.
  a_reset_clear: assert property ( // R10
    @(posedge clk)
    $rose(reset_n) |-> flags_r == 8'h00 && enable_r == 8'h00)
    else $error("flags or enables not zero after reset");

  // A group event sets bit 6 at the next edge.
  a_set_group: assert property ( // R1
    @(posedge clk) disable iff (!reset_n)
    ev_if.set_pulse[PTIF_BIT_PWM_GROUP] |=> flags_r[PTIF_BIT_PWM_GROUP])
    else $error("group flag not set");

  // Writing the group clearing byte drops bit 6 and leaves the low flags alone.
  a_clear_group: assert property ( // R2
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_FLAGS &&
    avs_writedata[7:0] == PTIF_CLR_PWM_GROUP && ev_if.set_pulse == 8'h00
    |=> !flags_r[PTIF_BIT_PWM_GROUP] && flags_r[5:0] == $past(flags_r[5:0]))
    else $error("group clear wrong");

  // Writing the channel 0 clearing byte drops bit 5.
  a_clear_ch0: assert property ( // R3
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_FLAGS &&
    avs_writedata[7:0] == PTIF_CLR_PWM_CH0 && !ev_if.set_pulse[PTIF_BIT_PWM_CH0]
    |=> !flags_r[PTIF_BIT_PWM_CH0])
    else $error("channel 0 clear wrong");

  // Writing the engine B clearing byte drops bit 1.
  a_clear_tb: assert property ( // R4
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_FLAGS &&
    avs_writedata[7:0] == PTIF_CLR_TOUCH_B && !ev_if.set_pulse[PTIF_BIT_TOUCH_B]
    |=> !flags_r[PTIF_BIT_TOUCH_B])
    else $error("engine B clear wrong");

  // Writing the engine A clearing byte drops bit 0.
  a_clear_ta: assert property ( // R5
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_FLAGS &&
    avs_writedata[7:0] == PTIF_CLR_TOUCH_A && !ev_if.set_pulse[PTIF_BIT_TOUCH_A]
    |=> !flags_r[PTIF_BIT_TOUCH_A])
    else $error("engine A clear wrong");

  // A set in the cycle of a clearing write still leaves its flag up.
  a_set_wins: assert property ( // R11
    @(posedge clk) disable iff (!reset_n)
    |ev_if.set_pulse
    |=> (flags_r & $past(ev_if.set_pulse)) == $past(ev_if.set_pulse))
    else $error("set lost to clear");

  // The group request follows its flag and enable bit, with no extra delay.
  a_gate_group: assert property ( // R6
    @(posedge clk) disable iff (!reset_n)
    irq_req[PTIF_BIT_PWM_GROUP] ==
    (flags_r[PTIF_BIT_PWM_GROUP] && enable_r[PTIF_BIT_PWM_GROUP]))
    else $error("group gating wrong");

  // With its enable low for two cycles, channel 0 never requests.
  a_gate_ch0: assert property ( // R7
    @(posedge clk) disable iff (!reset_n)
    !enable_r[PTIF_BIT_PWM_CH0] && !$past(enable_r[PTIF_BIT_PWM_CH0])
    |-> !irq_req[PTIF_BIT_PWM_CH0])
    else $error("channel 0 not blocked");

  // Engine B requests while its flag and enable stand together.
  a_gate_tb: assert property ( // R8
    @(posedge clk) disable iff (!reset_n)
    flags_r[PTIF_BIT_TOUCH_B] && enable_r[PTIF_BIT_TOUCH_B] ##1
    flags_r[PTIF_BIT_TOUCH_B] && enable_r[PTIF_BIT_TOUCH_B] |-> irq_req[PTIF_BIT_TOUCH_B])
    else $error("engine B not raised");

  // Engine A requests while its flag and enable stand together.
  a_gate_ta: assert property ( // R9
    @(posedge clk) disable iff (!reset_n)
    flags_r[PTIF_BIT_TOUCH_A] && enable_r[PTIF_BIT_TOUCH_A] ##1
    flags_r[PTIF_BIT_TOUCH_A] && enable_r[PTIF_BIT_TOUCH_A] |-> irq_req[PTIF_BIT_TOUCH_A])
    else $error("engine A not raised");

  // The combined request is high exactly while any source requests.
  a_irq_level: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    irq == (irq_req != 8'h00))
    else $error("combined request wrong");

  // Every request bit is its flag and enable together, and nothing else.
  a_req_match: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    irq_req == (flags_r & enable_r))
    else $error("request bits do not match flags and enables");

  // Without a write to the flag register no flag ever drops.
  // This is what keeps a request standing until software clears it.
  a_flag_sticky: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    !(wr_take && avs_address == PTIF_ADR_FLAGS)
    |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag dropped without a write");

  // A flag written with a one stays as it was.
  a_one_keeps: assert property ( // R11
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_FLAGS
    |=> ($past(flags_r) & $past(avs_writedata[7:0]) & ~flags_r) == 8'h00)
    else $error("flag written one was lost");

  // A flag written with a zero falls unless its event fires in the same cycle.
  a_zero_clears: assert property ( // R11
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_FLAGS
    |=> (flags_r & ~$past(avs_writedata[7:0]) & ~$past(ev_if.set_pulse)) == 8'h00)
    else $error("flag written zero was kept");

  // An enable write lands whole, with the unused bits kept at zero.
  a_enable_write: assert property ( // R6 R7 R8 R9
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == PTIF_ADR_ENABLE
    |=> enable_r == ($past(avs_writedata[7:0]) & PTIF_IMPL_MASK))
    else $error("enable write did not land");

  // A write without byte lane 0 changes no enable.
  a_lane_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_take && !avs_byteenable[0] |=> enable_r == $past(enable_r))
    else $error("write without lane 0 acted");

  // The request status register ignores writes; enables stay put.
  a_status_ro: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_take && avs_address == PTIF_ADR_IRQST |=> enable_r == $past(enable_r))
    else $error("status write acted");

  // Bits with no source always read zero in both registers.
  a_unused_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    ((flags_r | enable_r) & ~PTIF_IMPL_MASK) == 8'h00)
    else $error("unused bit set");

  // A request meets exactly one wait cycle, then the answer cycle.
  a_wait_once: assert property (
    @(posedge clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer did not follow one wait cycle");

  // Waitrequest drops for one cycle only; a request still held after it is answered again two cycles later.
  a_wait_short: assert property (
    @(posedge clk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // In the answer cycle of a read the upper lanes carry zero.
  a_rdata_upper: assert property (
    @(posedge clk) disable iff (!reset_n)
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");

endmodule
`default_nettype wire

// *** ptif_top_tb.sv ***
// Self-checking testbench for the PWM and touch-key interrupt flag block.
// Assumes ptif_pkg and the design files are compiled first; one clock, bus at lane 0.
`timescale 1ns/100ps
`default_nettype none
module ptif_top_tb;
  import ptif_pkg::*;
  logic        clk;             // System clock, 100 MHz.
  logic        reset_n;         // Asynchronous active-low reset.
  logic [9:0]  avs_address;     // Bus byte address.
  logic        avs_read;        // Bus read strobe.
  logic        avs_write;       // Bus write strobe.
  logic [31:0] avs_writedata;   // Bus write data.
  logic [3:0]  avs_byteenable;  // Bus byte lanes.
  logic [31:0] avs_readdata;    // Bus read data.
  logic        avs_waitrequest; // Bus stall.
  logic [3:0]  ev;              // Events: 3 group, 2 channel 0, 1 engine b, 0 engine a.
  logic [7:0]  irq_req;         // Per-source requests.
  logic        irq;             // Combined request.
  int          err_count;       // Mismatches seen.
  int          samples_checked; // Comparisons made.
  int          bitpos [4] = '{0, 1, 5, 6};            // Flag position per event index.
  logic [7:0]  clrv [4] = '{8'hfe, 8'hfd, 8'hdf, 8'hbf}; // Clearing byte per event index.

  ptif_top uut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_group_period_end(ev[3]), .pwm_ch0_period_end(ev[2]),
    .touch_b_scan_done(ev[1]), .touch_a_scan_done(ev[0]), .irq_req(irq_req), .irq(irq));

  // The clock toggles every half period.
  always #5 clk = ~clk;

  // One comparison; four-state equality so an unknown never matches.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access: raised just after an edge, held until waitrequest is sampled
  // low at a rising edge, where read data are taken and the request is released.
  task automatic bus(input logic wr, input logic [9:0] adr, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= adr;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) check(32'hdead, 32'h0);
  endtask

  task automatic wr(input logic [9:0] adr, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, adr, d, q);
  endtask

  task automatic rd(input logic [9:0] adr, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, adr, 8'h00, q);
    check(q, {24'h000000, exp});
  endtask

  // A rising event level, held two cycles, then a settle time for the flag.
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    repeat (2) @(posedge clk);
    ev[i] <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset;
    rd(PTIF_ADR_ENABLE, 8'h00);
    rd(PTIF_ADR_FLAGS, 8'h00);
    check({31'h0, irq}, 32'h0);
    rd(10'h3fc, 8'h00);
    wr(PTIF_ADR_ENABLE, 8'hff);
    rd(PTIF_ADR_ENABLE, 8'h63);
    wr(PTIF_ADR_ENABLE, 8'h00);
    $display("test reset and enable done");
  endtask

  // Each source alone: set, blocked, allowed, then cleared by its own byte.
  task automatic t_sources;
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'h01 << bitpos[i];
      pulse(i);
      rd(PTIF_ADR_FLAGS, m);
      check({23'h0, irq_req, irq}, 32'h0);
      wr(PTIF_ADR_ENABLE, m);
      repeat (2) @(negedge clk);
      check({23'h0, irq_req, irq}, {23'h0, m, 1'b1});
      wr(PTIF_ADR_FLAGS, clrv[i]);
      repeat (2) @(negedge clk);
      check({23'h0, irq_req, irq}, 32'h0);
      rd(PTIF_ADR_FLAGS, 8'h00);
      wr(PTIF_ADR_ENABLE, 8'h00);
    end
    $display("test single sources done");
  endtask

  // All flags up: one clearing byte must leave the others standing.
  task automatic t_keep;
    for (int i = 0; i < 4; i++) pulse(i);
    rd(PTIF_ADR_FLAGS, 8'h63);
    wr(PTIF_ADR_FLAGS, 8'hbf);
    rd(PTIF_ADR_FLAGS, 8'h23);
    wr(PTIF_ADR_FLAGS, 8'hfd);
    rd(PTIF_ADR_FLAGS, 8'h21);
    wr(PTIF_ADR_ENABLE, 8'h01);
    repeat (2) @(negedge clk);
    check({23'h0, irq_req, irq}, 32'h3);
    rd(PTIF_ADR_IRQST, 8'h01);
    wr(PTIF_ADR_FLAGS, 8'h00);
    rd(PTIF_ADR_FLAGS, 8'h00);
    check({31'h0, irq}, 32'h0);
    $display("test selective clear done");
  endtask

  // A set in the very cycle of a clearing write wins; writes without lane 0 or to
  // the status register do nothing; a reset in mid-run clears everything.
  task automatic t_race;
    wr(PTIF_ADR_ENABLE, 8'h01);
    fork
      wr(PTIF_ADR_FLAGS, 8'h00);
      begin
        repeat (2) @(posedge clk);
        ev[0] <= 1'b1;
        repeat (2) @(posedge clk);
        ev[0] <= 1'b0;
      end
    join
    rd(PTIF_ADR_FLAGS, 8'h01);
    wr(PTIF_ADR_IRQST, 8'h00);
    rd(PTIF_ADR_FLAGS, 8'h01);
    avs_byteenable <= 4'he;
    wr(PTIF_ADR_ENABLE, 8'h00);
    avs_byteenable <= 4'h1;
    rd(PTIF_ADR_ENABLE, 8'h01);
    rd(PTIF_ADR_IRQST, 8'h01);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(PTIF_ADR_FLAGS, 8'h00);
    rd(PTIF_ADR_ENABLE, 8'h00);
    check({31'h0, irq}, 32'h0);
    $display("test set against clear and reset done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: the tests need a few hundred cycles; this allows far more.
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    ev = 4'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_sources();
    t_keep();
    t_race();
    end_of_test();
  end
endmodule
`default_nettype wire
